// File: logic/afecfg_regs.v
// Slot B front end and digital integration configuration register bank.
// Assumes a host serial port decoder on clk presents one-cycle write and
// read strobes with an 8-bit register address; channel 2..4 gains arrive
// from the per-channel gain register held elsewhere.
`timescale 1ns/1ps
`default_nettype none
`include "afecfg_map.vh"

module afecfg_regs (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Host register port
  input  wire        reg_wr_en,
  input  wire        reg_rd_en,
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wr_data,
  output reg  [15:0] reg_rd_data,
  output reg         reg_rd_hit,
  // Per-channel gain bits 11:6 from the shared gain register
  input  wire [5:0]  second_slot_ext_gains,
  // Second slot window
  output wire [4:0]  second_slot_window_width,
  output wire [5:0]  second_slot_window_coarse_shift,
  output wire [4:0]  second_slot_window_fine_shift,
  // Second slot front end
  output wire [7:0]  second_slot_front_end_code,
  output wire        second_slot_mode_normal,
  output wire        second_slot_mode_digint,
  output wire        second_slot_per_channel_gain_on,
  output wire [1:0]  second_slot_gain_code,
  output wire [7:0]  second_slot_channel_gains,
  output wire [15:0] second_slot_path_word,
  output reg  [1:0]  second_slot_path_select,
  // Digital integration
  output wire        second_slot_integration_on,
  output wire        first_slot_integration_on,
  output wire        integration_gap_select,
  output wire [4:0]  second_slot_gap_length,
  output wire        second_slot_pairing_select,
  output wire        first_slot_pairing_select
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  reg [15:0] window_reg;
  reg [15:0] window_next;
  reg [15:0] mode_reg;
  reg [15:0] mode_next;
  reg [15:0] path_reg;
  reg [15:0] path_next;
  reg [15:0] digen_reg;
  reg [15:0] digen_next;
  reg [15:0] digopt_reg;
  reg [15:0] digopt_next;
  reg [15:0] rd_data_next;
  reg        rd_hit_next;

  // Whole words are kept, reserved bits included, so a read returns exactly
  // what was written; reserved values are software's duty
  always @* begin
    window_next = window_reg;
    mode_next   = mode_reg;
    path_next   = path_reg;
    digen_next  = digen_reg;
    digopt_next = digopt_reg;
    if (reg_wr_en) begin
      case (reg_addr)
        `AFECFG_ADDR_WINDOW: window_next = reg_wr_data;
        `AFECFG_ADDR_MODE:   mode_next   = reg_wr_data;
        `AFECFG_ADDR_PATH:   path_next   = reg_wr_data;
        `AFECFG_ADDR_DIGEN:  digen_next  = reg_wr_data;
        `AFECFG_ADDR_DIGOPT: digopt_next = reg_wr_data;
        default: begin
          // Unmapped writes are dropped; no shadow copy exists to catch them
          window_next = window_reg;
        end
      endcase
    end
  end

  // Defaults load on every clock edge with reset high, so a reset in mid-run restores them too
  always @(posedge clk) begin
    if (reset) begin
      window_reg <= `AFECFG_RST_WINDOW;
      mode_reg   <= `AFECFG_RST_MODE;
      path_reg   <= `AFECFG_RST_PATH;
      digen_reg  <= `AFECFG_RST_DIGEN;
      digopt_reg <= `AFECFG_RST_DIGOPT;
    end else begin
      window_reg <= window_next;
      mode_reg   <= mode_next;
      path_reg   <= path_next;
      digen_reg  <= digen_next;
      digopt_reg <= digopt_next;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Unmapped addresses read zero with the hit flag low; the read sees the
  // stored word, so a write in the same cycle shows only on the next read
  always @* begin
    rd_data_next = reg_rd_data;
    rd_hit_next  = 1'b0;
    if (reg_rd_en) begin
      rd_hit_next = 1'b1;
      case (reg_addr)
        `AFECFG_ADDR_WINDOW: rd_data_next = window_reg;
        `AFECFG_ADDR_MODE:   rd_data_next = mode_reg;
        `AFECFG_ADDR_PATH:   rd_data_next = path_reg;
        `AFECFG_ADDR_DIGEN:  rd_data_next = digen_reg;
        `AFECFG_ADDR_DIGOPT: rd_data_next = digopt_reg;
        default: begin
          rd_data_next = 16'h0000;
          rd_hit_next  = 1'b0;
        end
      endcase
    end
  end

  // Read data holds until the next read; the hit flag is a one-cycle pulse
  always @(posedge clk) begin
    if (reset) begin
      reg_rd_data <= 16'h0000;
      reg_rd_hit  <= 1'b0;
    end else begin
      reg_rd_data <= rd_data_next;
      reg_rd_hit  <= rd_hit_next;
    end
  end

  // ----------------------------------------
  // Window fields
  // ----------------------------------------
  assign second_slot_window_width        = window_reg[`AFECFG_WIN_WIDTH_HI:`AFECFG_WIN_WIDTH_LO];
  assign second_slot_window_coarse_shift = window_reg[`AFECFG_WIN_COARSE_HI:`AFECFG_WIN_COARSE_LO];
  assign second_slot_window_fine_shift   = window_reg[`AFECFG_WIN_FINE_HI:`AFECFG_WIN_FINE_LO];

  // ----------------------------------------
  // Front end mode and gain
  // ----------------------------------------
  assign second_slot_front_end_code      = mode_reg[`AFECFG_MODE_CODE_HI:`AFECFG_MODE_CODE_LO];
  assign second_slot_mode_normal         = (second_slot_front_end_code == `AFECFG_MODE_NORMAL);
  assign second_slot_mode_digint         = (second_slot_front_end_code == `AFECFG_MODE_DIGINT);
  assign second_slot_per_channel_gain_on = mode_reg[`AFECFG_MODE_IND_BIT];
  assign second_slot_gain_code           = mode_reg[`AFECFG_MODE_GAIN_HI:`AFECFG_MODE_GAIN_LO];

  // Channel gains packed ch4..ch1, two bits each, code 0 = highest gain
  wire [1:0] second_slot_ch4_gain = second_slot_ext_gains[5:4];
  wire [1:0] second_slot_ch3_gain = second_slot_ext_gains[3:2];
  wire [1:0] second_slot_ch2_gain = second_slot_ext_gains[1:0];
  // Channel 1 slot is unused in the external word; it always takes the own code
  wire [7:0] ext_gain_word = {second_slot_ch4_gain, second_slot_ch3_gain, second_slot_ch2_gain, 2'b00};

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_gain
      if (ch == 0) begin : g_own
        assign second_slot_channel_gains[1:0] = second_slot_gain_code;
      end else begin : g_ext
        assign second_slot_channel_gains[2*ch+1:2*ch] = second_slot_per_channel_gain_on ?
          ext_gain_word[2*ch+1:2*ch] : second_slot_gain_code;
      end
    end
  endgenerate

  // ----------------------------------------
  // Path connection decode
  // ----------------------------------------
  assign second_slot_path_word = path_reg;
  always @* begin
    case (path_reg)
      `AFECFG_PATH_FULL:    second_slot_path_select = `AFECFG_PATH_SEL_FULL;
      `AFECFG_PATH_AMPCONV: second_slot_path_select = `AFECFG_PATH_SEL_AMP;
      `AFECFG_PATH_DIGINT:  second_slot_path_select = `AFECFG_PATH_SEL_DIG;
      default:              second_slot_path_select = `AFECFG_PATH_SEL_RSV;
    endcase
  end

  // ----------------------------------------
  // Digital integration controls
  // ----------------------------------------
  assign second_slot_integration_on = digen_reg[`AFECFG_DIGEN_B_BIT];
  assign first_slot_integration_on  = digen_reg[`AFECFG_DIGEN_A_BIT];
  assign integration_gap_select     = digopt_reg[`AFECFG_GAP_BIT];
  // Zero gap means the negative and positive regions abut
  assign second_slot_gap_length     = integration_gap_select ? second_slot_window_fine_shift : 5'h00;
  assign second_slot_pairing_select = digopt_reg[`AFECFG_PAIR_B_BIT];
  assign first_slot_pairing_select  = digopt_reg[`AFECFG_PAIR_A_BIT];

endmodule

`default_nettype wire

// File: logic/afecfg_map.vh
// Register offsets, field positions and reset values of the slot B front end
// and digital integration configuration bank. Definitions only.
`ifndef AFECFG_MAP_VH
`define AFECFG_MAP_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define AFECFG_ADDR_WINDOW   8'h3B
`define AFECFG_ADDR_MODE     8'h44
`define AFECFG_ADDR_PATH     8'h45
`define AFECFG_ADDR_DIGEN    8'h58
`define AFECFG_ADDR_DIGOPT   8'h5A

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AFECFG_RST_WIDTH     5'h04
`define AFECFG_RST_COARSE    6'h17
`define AFECFG_RST_FINE      5'h1C
`define AFECFG_RST_WINDOW    16'h22FC
`define AFECFG_RST_MODE      16'h1C38
`define AFECFG_RST_PATH      16'hADA5
`define AFECFG_RST_DIGEN     16'h0000
`define AFECFG_RST_DIGOPT    16'h0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AFECFG_WIN_WIDTH_HI  15
`define AFECFG_WIN_WIDTH_LO  11
`define AFECFG_WIN_COARSE_HI 10
`define AFECFG_WIN_COARSE_LO 5
`define AFECFG_WIN_FINE_HI   4
`define AFECFG_WIN_FINE_LO   0
`define AFECFG_MODE_CODE_HI  15
`define AFECFG_MODE_CODE_LO  8
`define AFECFG_MODE_IND_BIT  6
`define AFECFG_MODE_GAIN_HI  1
`define AFECFG_MODE_GAIN_LO  0
`define AFECFG_DIGEN_B_BIT   13
`define AFECFG_DIGEN_A_BIT   12
`define AFECFG_GAP_BIT       7
`define AFECFG_PAIR_B_BIT    6
`define AFECFG_PAIR_A_BIT    5

// ----------------------------------------
// Codes
// ----------------------------------------
`define AFECFG_MODE_NORMAL   8'h1C
`define AFECFG_MODE_DIGINT   8'h1D
`define AFECFG_PATH_FULL     16'hADA5
`define AFECFG_PATH_AMPCONV  16'hB065
`define AFECFG_PATH_DIGINT   16'hAE65
`define AFECFG_PATH_SEL_FULL 2'h0
`define AFECFG_PATH_SEL_AMP  2'h1
`define AFECFG_PATH_SEL_DIG  2'h2
`define AFECFG_PATH_SEL_RSV  2'h3

`endif

// File: verif/afecfg_regs_properties.sv
// Port checks for the slot B configuration bank.
// Assumes a bind into afecfg_regs; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module afecfg_regs_properties (
  // Clock, reset and host port
  input wire logic        clk, reset, reg_wr_en, reg_rd_en, reg_rd_hit,
  input wire logic [7:0]  reg_addr, second_slot_front_end_code, second_slot_channel_gains,
  input wire logic [15:0] reg_wr_data, second_slot_path_word,
  // Field outputs
  input wire logic [5:0]  second_slot_ext_gains,
  input wire logic [4:0]  second_slot_window_width, second_slot_window_fine_shift, second_slot_gap_length,
  input wire logic [5:0]  second_slot_window_coarse_shift,
  input wire logic [1:0]  second_slot_gain_code, second_slot_path_select,
  input wire logic        second_slot_mode_normal, second_slot_mode_digint, second_slot_per_channel_gain_on,
  input wire logic        second_slot_integration_on, first_slot_integration_on, integration_gap_select,
  input wire logic        second_slot_pairing_select, first_slot_pairing_select
);
  wire logic map_hit = reg_addr inside {8'h3B, 8'h44, 8'h45, 8'h58, 8'h5A};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_window_write: assert property (reg_wr_en && reg_addr == 8'h3B |=> {second_slot_window_width,
    second_slot_window_coarse_shift, second_slot_window_fine_shift} == $past(reg_wr_data)) else $error("window bad");
  a_mode_decode: assert property ({second_slot_mode_normal, second_slot_mode_digint} ==
    {second_slot_front_end_code == 8'h1C, second_slot_front_end_code == 8'h1D}) else $error("mode decode bad");
  a_gain_route: assert property (second_slot_channel_gains == (second_slot_per_channel_gain_on ?
    {second_slot_ext_gains, second_slot_gain_code} : {4{second_slot_gain_code}})) else $error("gain route bad");
  a_path_decode: assert property (second_slot_path_select == (second_slot_path_word == 16'hADA5 ? 2'h0 :
    second_slot_path_word == 16'hB065 ? 2'h1 : second_slot_path_word == 16'hAE65 ? 2'h2 : 2'h3)) else $error("path bad");
  a_enable_write: assert property (reg_wr_en && reg_addr == 8'h58 |=>
    {second_slot_integration_on, first_slot_integration_on} == $past(reg_wr_data[13:12])) else $error("enable bad");
  a_pairing_write: assert property (reg_wr_en && reg_addr == 8'h5A |=>
    {second_slot_pairing_select, first_slot_pairing_select} == $past(reg_wr_data[6:5])) else $error("pairing bad");
  a_gap_length: assert property (second_slot_gap_length == (integration_gap_select ?
    second_slot_window_fine_shift : 5'h00)) else $error("gap length bad");
  a_read_hit: assert property (reg_rd_en |=> reg_rd_hit == $past(map_hit)) else $error("read hit bad");
endmodule
bind afecfg_regs afecfg_regs_properties chk_u (.*);
`default_nettype wire

// File: verif/afecfg_regs_test.sv
// Bench for the slot B configuration bank; reads are checked through a queue.
// Assumes afecfg_regs and its bound checker; drives the host port itself.
`timescale 1ns/1ps
`default_nettype none
module afecfg_regs_test;
  // ----
  // Signals
  // ----
  logic        clk = 1'b0, reset = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0, reg_rd_hit;
  logic [7:0]  reg_addr = 8'h00, second_slot_front_end_code, second_slot_channel_gains, ad [6];
  logic [15:0] reg_wr_data = 16'h0000, reg_rd_data, second_slot_path_word, mdl [256], q [$], m, o;
  logic [5:0]  second_slot_ext_gains = 6'h00, second_slot_window_coarse_shift;
  logic [4:0]  second_slot_window_width, second_slot_window_fine_shift, second_slot_gap_length;
  logic [1:0]  second_slot_gain_code, second_slot_path_select;
  logic        second_slot_mode_normal, second_slot_mode_digint, second_slot_per_channel_gain_on,
               second_slot_integration_on, first_slot_integration_on, integration_gap_select,
               second_slot_pairing_select, first_slot_pairing_select;
  logic [31:0] seed = 32'hcbca;
  int          n_mismatch = 0, n_compared = 0;
  afecfg_regs dut_u (.*);
  always #10 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One access; read note taken before the write lands, since a same-cycle read sees the old value
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    bit k = a inside {8'h3B, 8'h44, 8'h45, 8'h58, 8'h5A};
    @(posedge clk) #1;
    reg_wr_en = w;
    reg_rd_en = r;
    reg_addr = a;
    reg_wr_data = d;
    if (r && k) q.push_back(mdl[a]);
    if (w && k) mdl[a] = d;
    @(posedge clk) #1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
  endtask
  always @(posedge clk) if (reg_rd_hit === 1'b1) begin
    if (q.size() == 0) chk("read hit", 16'h0001, 16'h0000);
    else chk("read data", reg_rd_data, q.pop_front());
  end
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog: the run needs about 1000 cycles, so 10000 means a hang
  initial begin
    #200000;
    n_mismatch++;
    test_done;
  end
  initial begin
    ad = '{8'h3B, 8'h44, 8'h45, 8'h58, 8'h5A, 8'h3C};
    foreach (mdl[i]) mdl[i] = 16'h0000;
    mdl[8'h3B] = {5'h04, 6'h17, 5'h1C};
    mdl[8'h44] = {8'h1C, 2'h0, 4'hE, 2'h0};
    mdl[8'h45] = 16'hADA5;
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    foreach (ad[i]) acc(1'b0, 1'b1, ad[i], 16'h0000);
    chk("unmapped read", reg_rd_data, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 1'b0, 8'h45, i == 0 ? 16'hADA5 : i == 1 ? 16'hB065 : i == 2 ? 16'hAE65 : 16'hAE66);
      chk("path select", {14'h0000, second_slot_path_select}, 16'(i));
      acc(1'b1, 1'b0, 8'h44, {8'h1C + 8'(i), 8'h34});
      chk("mode flags", {second_slot_mode_normal, second_slot_mode_digint}, {i == 0, i == 1});
    end
    // Random words everywhere, unmapped writes included, each written and read in one cycle
    repeat (40) foreach (ad[i]) begin
      seed = xs(seed);
      second_slot_ext_gains = seed[21:16];
      acc(1'b1, 1'b1, ad[i], seed[15:0]);
      acc(1'b0, 1'b1, ad[i], 16'h0000);
      m = mdl[8'h44];
      o = mdl[8'h5A][7] ? mdl[8'h3B][4:0] : 5'h00;
      chk("gap length", {integration_gap_select, second_slot_gap_length}, {mdl[8'h5A][7], o[4:0]});
      chk("gains", second_slot_channel_gains, m[6] ? {seed[21:16], m[1:0]} : {4{m[1:0]}});
      chk("pairing", {second_slot_pairing_select, first_slot_pairing_select}, mdl[8'h5A][6:5]);
      chk("enables", {second_slot_integration_on, first_slot_integration_on}, mdl[8'h58][13:12]);
      chk("window", {second_slot_window_width, second_slot_window_coarse_shift, second_slot_window_fine_shift},
          mdl[8'h3B]);
      chk("mode fields", {second_slot_front_end_code, 5'h00, second_slot_per_channel_gain_on, second_slot_gain_code},
          {m[15:8], 5'h00, m[6], m[1:0]});
      chk("path word", second_slot_path_word, mdl[8'h45]);
    end
    repeat (3) @(posedge clk);
    chk("reads left", 16'(q.size()), 16'h0000);
    test_done;
  end
endmodule
`default_nettype wire
